// *** logic/eq_controller.sv ***
// Purpose: link master driven by software over an AXI4-Lite slave port
// Assumes: aclk at 50 MHz; link bit time is four quarter periods
// Notes: one data byte per command; a stop follows the last flag or a missing ack in checked mode
//
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module eq_controller (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  eq_link_if.ctl link
);
  typedef enum logic [3:0] {
    C_IDLE = 4'h1,
    C_START = 4'h2,
    C_BITS = 4'h4,
    C_STOP = 4'h8
  } ctl_state_e;

  ctl_state_e state_q;
  logic aw_got_q;
  logic w_got_q;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [7:0] qcnt_q;
  logic [1:0] phase_q;
  logic [1:0] np;
  logic tick;
  logic wr_fire;
  logic cmd_go;
  logic sda_s;
  logic [7:0] shift_q;
  logic [7:0] data_q;
  logic [3:0] bit_cnt_q;
  logic addr_phase_q;
  logic last_q;
  logic noack_q;
  logic open_q;
  logic nack_q;
  logic scl_hi_q;
  logic sda_hi_q;

  function automatic logic reg_mapped(input logic [3:0] a);
    return (a == eq_pkg::REG_CMD) || (a == eq_pkg::REG_STATUS);
  endfunction

  eq_sync2 #(.RST_VAL(1'h1)) u_sda_sync (
    .clk(aclk),
    .resetn(aresetn),
    .async_in(link.sda_i),
    .sync_out(sda_s)
  );

  assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
  // commands written while busy are answered but dropped
  assign cmd_go = wr_fire && (awaddr_q == eq_pkg::REG_CMD) && (state_q == C_IDLE) && wdata_q[31];

  // write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'h1;
      s_axi_wready <= 1'h1;
      s_axi_bvalid <= 1'h0;
      s_axi_bresp <= eq_pkg::RESP_OKAY;
      aw_got_q <= 1'h0;
      w_got_q <= 1'h0;
      awaddr_q <= '0;
      wdata_q <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'h0;
        aw_got_q <= 1'h1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'h0;
        w_got_q <= 1'h1;
        wdata_q <= {|s_axi_wstrb, s_axi_wdata[30:0]}; // bit 31 keeps the strobe
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'h1;
        s_axi_bresp <= reg_mapped(awaddr_q) ? eq_pkg::RESP_OKAY : eq_pkg::RESP_SLVERR;
        aw_got_q <= 1'h0;
        w_got_q <= 1'h0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'h0;
        s_axi_awready <= 1'h1;
        s_axi_wready <= 1'h1;
      end
    end
  end

  // read channel: answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'h1;
      s_axi_rvalid <= 1'h0;
      s_axi_rdata <= '0;
      s_axi_rresp <= eq_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'h0;
      s_axi_rvalid <= 1'h1;
      s_axi_rresp <= reg_mapped(s_axi_araddr) ? eq_pkg::RESP_OKAY : eq_pkg::RESP_SLVERR;
      s_axi_rdata <= '0;
      if (s_axi_araddr == eq_pkg::REG_STATUS) begin
        s_axi_rdata[eq_pkg::ST_BUSY_POS] <= (state_q != C_IDLE);
        s_axi_rdata[eq_pkg::ST_NACK_POS] <= nack_q;
        s_axi_rdata[eq_pkg::ST_OPEN_POS] <= open_q;
      end else if (s_axi_araddr == eq_pkg::REG_CMD) begin
        s_axi_rdata <= {21'h0, last_q, noack_q, 1'h0, data_q};
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'h0;
      s_axi_arready <= 1'h1;
    end
  end

  // quarter-bit timer; four quarters keep the link at its top rate
  assign tick = (qcnt_q == eq_pkg::QTR_LAST); // [RQ11]
  assign np = phase_q + 2'h1;
  always_ff @(posedge aclk) begin
    if (!aresetn || state_q == C_IDLE) begin
      qcnt_q <= '0;
      phase_q <= '0;
    end else if (tick) begin
      qcnt_q <= '0;
      phase_q <= np;
    end else begin
      qcnt_q <= qcnt_q + 8'h1;
    end
  end

  // bit engine: data moves in quarter 1 while the clock is low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= C_IDLE;
      shift_q <= '0;
      data_q <= '0;
      bit_cnt_q <= eq_pkg::BIT_FIRST;
      addr_phase_q <= 1'h0;
      last_q <= 1'h0;
      noack_q <= 1'h0;
      open_q <= 1'h0;
      nack_q <= 1'h0;
      scl_hi_q <= 1'h1;
      sda_hi_q <= 1'h1;
    end else begin
      case (state_q)
        C_IDLE: begin
          if (cmd_go) begin
            data_q <= wdata_q[7:0];
            noack_q <= wdata_q[eq_pkg::CMD_NOACK_POS];
            last_q <= wdata_q[eq_pkg::CMD_LAST_POS];
            nack_q <= 1'h0;
            bit_cnt_q <= eq_pkg::BIT_FIRST;
            // an open transfer carries on with the next data byte
            addr_phase_q <= !open_q; // [RQ8]
            shift_q <= open_q ? wdata_q[7:0]
              : {eq_pkg::ADDR_BASE[7:2], wdata_q[eq_pkg::CMD_STRAP_POS], eq_pkg::ADDR_DIR_WRITE};
            state_q <= open_q ? C_BITS : C_START;
          end
        end
        C_START: begin
          if (tick && np == 2'h1) begin
            sda_hi_q <= 1'h0; // [RQ2]
          end else if (tick && np == 2'h0) begin
            scl_hi_q <= 1'h0;
            open_q <= 1'h1;
            state_q <= C_BITS;
          end
        end
        C_BITS: begin
          if (tick && np == 2'h1) begin
            // release during the ninth pulse so the slave can answer
            sda_hi_q <= (bit_cnt_q == eq_pkg::BYTE_BITS) ? 1'h1 : shift_q[7]; // [RQ1] [RQ4] [RQ5]
          end else if (tick && np == 2'h2) begin
            scl_hi_q <= 1'h1;
          end else if (tick && np == 2'h3 && bit_cnt_q == eq_pkg::BYTE_BITS) begin
            if (sda_s && !noack_q) begin
              nack_q <= 1'h1; // [RQ6]
            end
          end else if (tick && np == 2'h0) begin
            scl_hi_q <= 1'h0;
            if (bit_cnt_q != eq_pkg::BYTE_BITS) begin
              shift_q <= {shift_q[6:0], 1'h0};
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end else begin
              bit_cnt_q <= eq_pkg::BIT_FIRST;
              if (nack_q) begin
                state_q <= C_STOP; // [RQ6]
              end else if (addr_phase_q) begin
                // unchecked mode goes on regardless of the ack level
                addr_phase_q <= 1'h0; // [RQ7]
                shift_q <= data_q;
              end else begin
                state_q <= last_q ? C_STOP : C_IDLE; // [RQ8]
              end
            end
          end
        end
        C_STOP: begin
          if (tick && np == 2'h1) begin
            sda_hi_q <= 1'h0;
          end else if (tick && np == 2'h2) begin
            scl_hi_q <= 1'h1;
          end else if (tick && np == eq_pkg::PH_LAST) begin
            sda_hi_q <= 1'h1; // [RQ3]
          end else if (tick && np == 2'h0) begin
            open_q <= 1'h0;
            state_q <= C_IDLE;
          end
        end
        default: begin
          state_q <= C_IDLE;
        end
      endcase
    end
  end

  // open drain: drive low when not high
  assign link.scl_o = 1'h0;
  assign link.scl_oe_n = scl_hi_q;
  assign link.ctl_sda_o = 1'h0;
  assign link.ctl_sda_oe_n = sda_hi_q;
endmodule

// *** logic/eq_device.sv ***
// Purpose: equalizer end of the link; receives and holds settings
// Assumes: link_clk oversamples the link well above 400 kHz
// Notes: write-only slave; settings appear as plain outputs
// Behaviour
// [RQ1] data changes only while clock low
// [RQ2] data falling with clock high starts
// [RQ3] data rising with clock high stops
// [RQ4] eight bits, msb first, then ack slot
// [RQ5] addressed device pulls ack low every byte
// [RQ6] master may stop after missing ack
// [RQ7] master may skip checking ack
// [RQ8] start, address, n data bytes, stop
// [RQ9] answer only address 84 or 86 write
// [RQ10] address bit follows strap pin level
// [RQ11] link clock at most 100 kbit/s
// [RQ12] top bit zero: coarse and fine volume
// [RQ13] attenuation is coarse plus fine sum
// [RQ14] top bit one: bits 6:4 pick band
// [RQ15] bit 3 cut, bits 2:0 2 dB steps
// [RQ16] reset: volume -17.25 dB, bands -12 dB
// [RQ17] apply each byte at its end
// [RQ18] store odd codes, ignore unused bands
`timescale 1ns/1ps
module eq_device (
  input wire logic link_clk,
  input wire logic link_resetn,
  input wire logic addr_strap,
  eq_link_if.dev link,
  output logic [2:0] coarse_attenuation_field,
  output logic [2:0] fine_attenuation_field,
  output logic [eq_pkg::BANDS-1:0] cut_boost_flag,
  output logic [eq_pkg::BANDS-1:0][2:0] band_level_field,
  output logic addressed
);
  typedef enum logic [3:0] {
    D_IDLE = 4'h1,
    D_ADDR = 4'h2,
    D_DATA = 4'h4,
    D_SKIP = 4'h8
  } dev_state_e;

  dev_state_e state_q;
  logic scl_s;
  logic sda_s;
  logic strap_s;
  logic scl_p_q;
  logic sda_p_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic ack_n_q;
  logic start_ev;
  logic stop_ev;
  logic scl_rise;
  logic scl_fall;
  logic addr_match;
  logic byte_done;
  logic [eq_pkg::BANDS-1:0] band_hit;
  logic vol_hit;

  // one-hot band decode; unused select codes give no hit
  function automatic logic [eq_pkg::BANDS-1:0] band_decode(input logic [2:0] sel);
    logic [eq_pkg::BANDS-1:0] hit;
    hit = '0;
    for (int i = 0; i < eq_pkg::BANDS; i++) begin
      if (sel == 3'(int'(eq_pkg::BAND_CODE_FIRST) + i)) begin
        hit[i] = 1'h1;
      end
    end
    return hit;
  endfunction

  // pins come from the controller's domain and the board
  eq_sync2 #(.RST_VAL(1'h1)) u_scl_sync (
    .clk(link_clk),
    .resetn(link_resetn),
    .async_in(link.scl_i),
    .sync_out(scl_s)
  );
  eq_sync2 #(.RST_VAL(1'h1)) u_sda_sync (
    .clk(link_clk),
    .resetn(link_resetn),
    .async_in(link.sda_i),
    .sync_out(sda_s)
  );
  eq_sync2 #(.RST_VAL(1'h1)) u_strap_sync (
    .clk(link_clk),
    .resetn(link_resetn),
    .async_in(addr_strap),
    .sync_out(strap_s)
  );

  // previous levels for edge detection, taken after synchronisation
  always_ff @(posedge link_clk) begin
    if (!link_resetn) begin
      scl_p_q <= 1'h1;
      sda_p_q <= 1'h1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // data edges only count as framing while the clock stays high
  assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s; // [RQ2]
  assign stop_ev = scl_s & scl_p_q & ~sda_p_q & sda_s; // [RQ3]
  // data is sampled on the clock rise, since it may move only while low
  assign scl_rise = scl_s & ~scl_p_q; // [RQ1]
  assign scl_fall = ~scl_s & scl_p_q;

  // fixed bits, strap level in bit 1, write direction only
  assign addr_match = (shift_q[7:eq_pkg::ADDR_FIXED_LSB] == eq_pkg::ADDR_BASE[7:eq_pkg::ADDR_FIXED_LSB]) // [RQ9]
    && (shift_q[eq_pkg::ADDR_STRAP_POS] == strap_s) // [RQ10]
    && (shift_q[0] == eq_pkg::ADDR_DIR_WRITE); // [RQ9]

  // the fall that closes the eighth bit ends the byte
  assign byte_done = scl_fall && (bit_cnt_q == eq_pkg::BYTE_BITS); // [RQ4]

  // byte type split; the volume byte ignores bit 6
  assign vol_hit = (state_q == D_DATA) && byte_done && !shift_q[eq_pkg::TYPE_POS]; // [RQ12] [RQ17]
  assign band_hit = ((state_q == D_DATA) && byte_done && shift_q[eq_pkg::TYPE_POS])
    ? band_decode(shift_q[eq_pkg::BAND_SELECT_HIGH_POS:eq_pkg::BAND_SEL_LSB]) // [RQ14] [RQ18]
    : '0;

  // transfer sequencing: start, address, then data bytes until stop
  always_ff @(posedge link_clk) begin
    if (!link_resetn) begin
      state_q <= D_IDLE;
    end else if (start_ev) begin
      state_q <= D_ADDR; // [RQ8]
    end else if (stop_ev) begin
      state_q <= D_IDLE; // [RQ8]
    end else begin
      case (state_q)
        D_IDLE: begin
          state_q <= D_IDLE;
        end
        D_ADDR: begin
          if (byte_done) begin
            state_q <= addr_match ? D_DATA : D_SKIP; // [RQ9] [RQ17]
          end
        end
        D_DATA: begin
          state_q <= D_DATA;
        end
        D_SKIP: begin
          state_q <= D_SKIP; // [RQ17]
        end
        default: begin
          state_q <= D_IDLE;
        end
      endcase
    end
  end

  // bit counter: 0..8 while shifting, 9 during the acknowledge pulse
  always_ff @(posedge link_clk) begin
    if (!link_resetn) begin
      bit_cnt_q <= eq_pkg::BIT_FIRST;
    end else if (start_ev || stop_ev) begin
      bit_cnt_q <= eq_pkg::BIT_FIRST;
    end else if (scl_rise && (bit_cnt_q < eq_pkg::BYTE_BITS)) begin
      bit_cnt_q <= bit_cnt_q + 4'h1; // [RQ4]
    end else if (byte_done) begin
      bit_cnt_q <= eq_pkg::ACK_SLOT; // [RQ4]
    end else if (scl_fall && (bit_cnt_q == eq_pkg::ACK_SLOT)) begin
      bit_cnt_q <= eq_pkg::BIT_FIRST;
    end
  end

  // msb arrives first, so shift left
  always_ff @(posedge link_clk) begin
    if (!link_resetn) begin
      shift_q <= '0;
    end else if (scl_rise && (bit_cnt_q < eq_pkg::BYTE_BITS) && (state_q != D_IDLE)) begin
      shift_q <= {shift_q[6:0], sda_s}; // [RQ4]
    end
  end

  // pull the line low from the eighth fall to the ninth fall;
  // a start or stop in the middle releases it at once
  always_ff @(posedge link_clk) begin
    if (!link_resetn) begin
      ack_n_q <= 1'h1;
    end else if (start_ev || stop_ev) begin
      ack_n_q <= 1'h1;
    end else if (byte_done) begin
      ack_n_q <= !(((state_q == D_ADDR) && addr_match) || (state_q == D_DATA)); // [RQ5]
    end else if (scl_fall && (bit_cnt_q == eq_pkg::ACK_SLOT)) begin
      ack_n_q <= 1'h1; // [RQ5]
    end
  end

  // open drain: output level is always low, enable is active low
  assign link.dev_sda_o = 1'h0;
  assign link.dev_sda_oe_n = ack_n_q;

  // volume store; codes 110 and 111 are held as written
  always_ff @(posedge link_clk) begin
    if (!link_resetn) begin
      coarse_attenuation_field <= eq_pkg::COARSE_RESET; // [RQ16]
      fine_attenuation_field <= eq_pkg::FINE_RESET; // [RQ16]
    end else if (vol_hit) begin
      // the analog stage sums coarse and fine steps
      coarse_attenuation_field <= shift_q[eq_pkg::COARSE_LSB +: 3]; // [RQ13] [RQ18]
      fine_attenuation_field <= shift_q[eq_pkg::FINE_LSB +: 3]; // [RQ13]
    end
  end

  // one store per band; each updates only on its own select code
  for (genvar b = 0; b < eq_pkg::BANDS; b++) begin : g_band
    always_ff @(posedge link_clk) begin
      if (!link_resetn) begin
        cut_boost_flag[b] <= eq_pkg::BAND_RESET[eq_pkg::CUT_BOOST_FLAG_POS]; // [RQ16]
        band_level_field[b] <= eq_pkg::BAND_RESET[eq_pkg::BAND_LEVEL_LSB +: 3]; // [RQ16]
      end else if (band_hit[b]) begin
        cut_boost_flag[b] <= shift_q[eq_pkg::CUT_BOOST_FLAG_POS]; // [RQ15]
        band_level_field[b] <= shift_q[eq_pkg::BAND_LEVEL_LSB +: 3]; // [RQ15]
      end
    end
  end

  // status for the board: high while a matched transfer is open
  always_ff @(posedge link_clk) begin
    if (!link_resetn) begin
      addressed <= 1'h0;
    end else begin
      addressed <= (state_q == D_DATA) && !start_ev && !stop_ev;
    end
  end
endmodule

// *** logic/eq_link_if.sv ***
// Purpose: two-wire link joining the controller and the equalizer end
// Assumes: open-drain wires with pull-ups; enables active low
// Notes: wire levels are resolved here from each end's enable
`timescale 1ns/1ps
interface eq_link_if;
  logic scl_o;
  logic scl_oe_n;
  logic ctl_sda_o;
  logic ctl_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic scl_i;
  logic sda_i;

  // pull-up wins unless an end drives; wired-and on the data line
  assign scl_i = scl_oe_n ? 1'h1 : scl_o;
  assign sda_i = (ctl_sda_oe_n ? 1'h1 : ctl_sda_o) & (dev_sda_oe_n ? 1'h1 : dev_sda_o);

  modport ctl(output scl_o, output scl_oe_n, output ctl_sda_o, output ctl_sda_oe_n, input scl_i, input sda_i);
  modport dev(output dev_sda_o, output dev_sda_oe_n, input scl_i, input sda_i);
endinterface

// *** logic/eq_pkg.sv ***
// Purpose: shared constants for the equalizer serial control link
// Assumes: 50 MHz controller clock, open-drain two-wire link
// Notes: both ends and the register map draw on these names
package eq_pkg;
  // chip address: bits 7:2 fixed, bit 1 from strap, bit 0 is direction
  localparam logic [7:0] ADDR_BASE = 8'h84;
  localparam logic ADDR_DIR_WRITE = 1'h0;
  localparam int ADDR_STRAP_POS = 1;
  localparam int ADDR_FIXED_LSB = 2;

  // bit counting within one byte and its acknowledge slot
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_SLOT = 4'h9;

  // data byte layout
  localparam int TYPE_POS = 7;
  localparam int COARSE_LSB = 3;
  localparam int FINE_LSB = 0;
  localparam int BAND_SEL_LSB = 4;
  localparam int BAND_SELECT_HIGH_POS = 6;
  localparam int CUT_BOOST_FLAG_POS = 3;
  localparam int BAND_LEVEL_LSB = 0;
  localparam int BANDS = 4;
  localparam logic [2:0] BAND_CODE_FIRST = 3'h1;

  // power-on settings: -15 dB coarse plus -2.25 dB fine, bands cut 12 dB
  localparam logic [2:0] COARSE_RESET = 3'h5;
  localparam logic [2:0] FINE_RESET = 3'h6;
  localparam logic [3:0] BAND_RESET = 4'he;

  // link timing
  localparam int ACLK_HZ = 50000000;
  localparam int SCL_MAX_HZ = 100000;
  localparam int QTR_CYC = ACLK_HZ / (4 * SCL_MAX_HZ);
  localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);
  localparam logic [1:0] PH_LAST = 2'h3;

  // controller register map
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int CMD_STRAP_POS = 8;
  localparam int CMD_NOACK_POS = 9;
  localparam int CMD_LAST_POS = 10;
  localparam int ST_BUSY_POS = 0;
  localparam int ST_NACK_POS = 1;
  localparam int ST_OPEN_POS = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** logic/eq_sync2.sv ***
// Purpose: two-flop synchroniser for one pin level
// Assumes: input is asynchronous to clk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module eq_sync2 #(
  parameter logic RST_VAL = 1'h1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_q;

  // both stages settle to the idle level of the line under reset
  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta_q <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// *** verification/eq_link_sva.sv ***
// Purpose: wire-level checks of the equalizer link
// Assumes: aclk samples the wires; the link is far slower
// Notes: bit count restarts at every start
`timescale 1ns/1ps
module eq_link_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic link_clk,
  input wire logic link_resetn,
  input wire logic ctl_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic scl_i,
  input wire logic sda_i
);
  logic scl_q, sda_q, first_q, acked_q, rise, start, stop;
  logic [3:0] cnt_q;
  logic [7:0] sh_q;
  logic [15:0] per_q;
  // wire edges, start and stop need clock high on both samples
  assign rise = scl_i && !scl_q;
  assign start = scl_i && scl_q && sda_q && !sda_i;
  assign stop = scl_i && scl_q && !sda_q && sda_i;
  always_ff @(posedge aclk) begin
    scl_q <= scl_i;
    sda_q <= sda_i;
  end
  // bit slot, 9 is the ack pulse
  always_ff @(posedge aclk) begin
    if (!aresetn || start) cnt_q <= 4'h0;
    else if (rise) cnt_q <= (cnt_q == 4'h9) ? 4'h1 : cnt_q + 4'h1;
  end
  // first byte is the chip address
  always_ff @(posedge aclk) begin
    if (!aresetn || start) begin
      first_q <= 1'b1;
      acked_q <= 1'b0;
    end else begin
      if (rise && cnt_q == 4'h9) first_q <= 1'b0;
      if (scl_i && scl_q && cnt_q == 4'h9 && first_q && !dev_sda_oe_n) acked_q <= 1'b1;
    end
  end
  // data bits only, the ack bit stays out
  always_ff @(posedge aclk) begin
    if (rise && cnt_q != 4'h8) sh_q <= {sh_q[6:0], sda_i};
  end
  // cycles since last rise, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn) per_q <= 16'hffff;
    else if (rise) per_q <= 16'h0;
    else if (per_q != 16'hffff) per_q <= per_q + 16'h1;
  end
  sequence ack_slot;
    scl_i && scl_q && cnt_q == 4'h9;
  endsequence
  sequence addr_acked;
    ack_slot ##0 (first_q && !dev_sda_oe_n);
  endsequence
  a_dev_sda_stable: assert property (@(posedge aclk) disable iff (!aresetn)
    scl_i && scl_q |-> $stable(dev_sda_oe_n)) else $error("device data moved in clock high");
  a_ctl_sda_stable: assert property (@(posedge aclk) disable iff (!aresetn)
    scl_i && scl_q && !start && !stop |-> $stable(ctl_sda_oe_n)) else $error("master data moved");
  a_start_then_low: assert property (@(posedge aclk) disable iff (!aresetn)
    start |-> ##[1:400] !scl_i) else $error("no clock after start");
  a_stop_goes_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    stop |-> (scl_i && sda_i) [*8]) else $error("bus busy after stop");
  a_master_ack_free: assert property (@(posedge aclk) disable iff (!aresetn)
    ack_slot |-> ctl_sda_oe_n) else $error("master drove ack slot");
  a_dev_pull_slot: assert property (@(posedge aclk) disable iff (!aresetn)
    scl_i && scl_q && !dev_sda_oe_n |-> cnt_q == 4'h9) else $error("device pulled outside ack");
  a_addr_pattern: assert property (@(posedge aclk) disable iff (!aresetn)
    addr_acked |-> sh_q[7:2] == 6'h21 && !sh_q[0]) else $error("ack on foreign address");
  a_ack_each_byte: assert property (@(posedge aclk) disable iff (!aresetn)
    ack_slot ##0 acked_q |-> !dev_sda_oe_n) else $error("data byte not acked");
  a_bit_period: assert property (@(posedge aclk) disable iff (!aresetn)
    rise |-> per_q >= 16'h1f3) else $error("link clock too fast");
  a_ack_low_level: assert property (@(posedge link_clk) disable iff (!link_resetn)
    !dev_sda_oe_n |-> !dev_sda_o) else $error("ack not low");
endmodule

// *** verification/equalizer_serial_control_test.sv ***
// Purpose: software writes must reach the equalizer settings
// Assumes: 50 MHz controller, 160 ns device link clock
// Notes: driver queues results; watchers pop on each result
`timescale 1ns/1ps
module equalizer_serial_control_test;
  localparam logic [21:0] RST = {3'h5, 3'h6, 4'hf, {4{3'h6}}};
  logic aclk = 1'b0;
  logic link_clk = 1'b0;
  logic aresetn = 1'b0;
  logic link_resetn = 1'b0;
  logic strap = 1'b1;
  logic poll = 1'b0;
  logic [3:0] awaddr = 4'h0;
  logic [3:0] araddr = 4'h0;
  logic [3:0] wstrb = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, adr;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [2:0] coarse, fine;
  logic [3:0] cut;
  logic [3:0][2:0] lvl;
  logic [21:0] m, seen = RST;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  logic [21:0] sq[$];
  int err_total = 0;
  int total_checks = 0;
  int seed = 32'hb1a9;
  wire logic [21:0] now_s = {coarse, fine, cut, lvl};
  eq_link_if link_a ();
  eq_controller eq_controller_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link_a));
  eq_device eq_device_i (.link_clk(link_clk), .link_resetn(link_resetn), .addr_strap(strap), .link(link_a),
    .coarse_attenuation_field(coarse), .fine_attenuation_field(fine), .cut_boost_flag(cut),
    .band_level_field(lvl), .addressed(adr));
  eq_link_sva eq_link_sva_i (.aclk(aclk), .aresetn(aresetn), .link_clk(link_clk), .link_resetn(link_resetn),
    .ctl_sda_oe_n(link_a.ctl_sda_oe_n), .dev_sda_o(link_a.dev_sda_o), .dev_sda_oe_n(link_a.dev_sda_oe_n),
    .scl_i(link_a.scl_i), .sda_i(link_a.sda_i));
  always #10 aclk = ~aclk;
  always #80 link_clk = ~link_clk;
  task end_of_test();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task expire();
    err_total++;
    end_of_test();
  endtask
  task tally(input string n, input logic [33:0] e, input logic [33:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task cmp_resp(input logic [1:0] e, input logic [1:0] g);
    tally("bresp", 34'(e), 34'(g));
  endtask
  task cmp_read(input logic [33:0] e, input logic [33:0] g);
    tally("read", e, g);
  endtask
  task cmp_set(input logic [21:0] e, input logic [21:0] g);
    tally("settings", 34'(e), 34'(g));
  endtask
  // master write; bready held until bvalid
  task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    bq.push_back(r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) bready <= 1'b0;
      n++;
      if (n > 60) expire();
    end while (awvalid || wvalid || bready);
  endtask
  // master read; a poll is not compared
  task rd(input logic [3:0] a, input logic [33:0] e, input logic p, output logic [31:0] d);
    int n;
    n = 0;
    d = 32'h0;
    if (!p) rq.push_back(e);
    @(posedge aclk);
    poll <= p;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        rready <= 1'b0;
        d = rdata;
      end
      n++;
      if (n > 60) expire();
    end while (arvalid || rready);
  endtask
  task st(input logic [31:0] e);
    logic [31:0] d;
    rd(eq_pkg::REG_STATUS, {eq_pkg::RESP_OKAY, e}, 1'b0, d);
    tally("addressed", 34'(e[2]), 34'(adr));
  endtask
  // a byte is about 4500 cycles
  task wait_idle();
    logic [31:0] s;
    int n;
    s = 32'h1;
    n = 0;
    while (s[eq_pkg::ST_BUSY_POS] !== 1'b0) begin
      rd(eq_pkg::REG_STATUS, 34'h0, 1'b1, s);
      n++;
      if (n > 4000) expire();
    end
  endtask
  task cmd(input logic [7:0] b, input logic a, input logic k, input logic l, input logic c);
    logic [31:0] w;
    w = {24'h0, b};
    w[eq_pkg::CMD_STRAP_POS] = a;
    w[eq_pkg::CMD_NOACK_POS] = k;
    w[eq_pkg::CMD_LAST_POS] = l;
    if (c) sq.push_back(m);
    wr(eq_pkg::REG_CMD, w, eq_pkg::RESP_OKAY);
    wait_idle();
    tally("pending", 34'h0, 34'(sq.size()));
  endtask
  // responses as they complete
  always @(posedge aclk) begin
    if (bvalid && bready) cmp_resp(bq.pop_front(), bresp);
    if (rvalid && rready && !poll) cmp_read(rq.pop_front(), {rresp, rdata});
  end
  // a settings change pops the oldest
  always @(posedge link_clk) begin
    if (link_resetn && now_s !== seen) begin
      seen <= now_s;
      cmp_set(sq.pop_front(), now_s);
    end
  end
  initial begin
    logic [7:0] b;
    logic [31:0] d;
    int r;
    m = RST;
    repeat (8) @(posedge link_clk);
    link_resetn <= 1'b1;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge link_clk);
    cmp_set(RST, now_s);
    rd(4'h8, {eq_pkg::RESP_SLVERR, 32'h0}, 1'b0, d);
    wr(4'hc, 32'hff, eq_pkg::RESP_SLVERR);
    wr(eq_pkg::REG_STATUS, 32'h7, eq_pkg::RESP_OKAY);
    st(32'h0);
    r = $random(seed);
    b = {1'b0, r[7], 3'($unsigned(r) % 5), r[2:0]};
    m[21:16] = b[5:0];
    cmd(b, 1'b1, 1'b0, 1'b0, 1'b1);
    st(32'h4);
    for (int i = 0; i < 4; i++) begin
      b = {1'b1, 3'(i + 1), 1'b0, 3'($random(seed))};
      m[12 + i] = 1'b0;
      m[3 * i +: 3] = b[2:0];
      cmd(b, 1'b1, 1'b0, 1'(i == 3), 1'b1);
    end
    st(32'h0);
    cmd(8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
    st(32'h2);
    cmd(8'h00, 1'b0, 1'b1, 1'b1, 1'b0);
    st(32'h0);
    strap <= 1'b0;
    repeat (20) @(posedge aclk);
    m[21:16] = 6'h33;
    cmd(8'h73, 1'b0, 1'b0, 1'b0, 1'b1);
    cmd(8'hd2, 1'b0, 1'b0, 1'b1, 1'b0);
    cmp_set(m, now_s);
    end_of_test();
  end
endmodule
